/* File: design/pmta_pkg.sv */
// Constants and carrier types for the program memory table-access unit.
// Assumes a single core clock and a synchronous active-high reset.
package pmta_pkg;
   localparam int PTR_W = 22;
   localparam int LOW_W = 21;
   localparam int TOP_BIT = 21;
   localparam int HOLD_SEL_W = 3;
   localparam int HOLD_N = 8;
   localparam int ERASE_LSB = 6;
   localparam int WBLK_LSB = 3;
   // Memory access control bit positions.
   localparam int MAC_SEL_PGM = 7;
   localparam int MAC_SEL_CFG = 6;
   localparam int MAC_ERASE = 4;
   localparam int MAC_WERR = 3;
   localparam int MAC_WEN = 2;
   localparam int MAC_WSTART = 1;
   localparam int MAC_RSTART = 0;
   localparam logic [7:0] MAC_RESET = 8'h00;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [21:0] PTR_RESET = 22'h000000;
   // Register select codes on the special function space port.
   localparam logic [2:0] REG_MAC = 3'h0;
   localparam logic [2:0] REG_LATCH = 3'h1;
   localparam logic [2:0] REG_PTR_L = 3'h2;
   localparam logic [2:0] REG_PTR_H = 3'h3;
   localparam logic [2:0] REG_PTR_U = 3'h4;
   // Pointer update forms of the table instructions.
   typedef enum logic [1:0] {
      PMTA_PLAIN = 2'h0,
      PMTA_POST_INC = 2'h1,
      PMTA_POST_DEC = 2'h2,
      PMTA_PRE_INC = 2'h3
   } pmta_mode_t;
   typedef struct packed {
      logic sel_pgm;
      logic sel_cfg;
      logic erase;
      logic werr;
      logic wen;
      logic wstart;
      logic rstart;
   } pmta_mac_t;
   typedef struct packed {
      logic valid;
      logic is_write;
      pmta_mode_t mode;
   } pmta_tbl_req_t;
endpackage : pmta_pkg

/* File: design/pmta_ptr_step.sv */
// Pointer arithmetic for the table instructions.
// Assumes nothing beyond the package; purely combinational.
`timescale 1ns/10ps
`default_nettype none
module pmta_ptr_step (
   input wire logic [21:0] ptr_i,
   input wire pmta_pkg::pmta_mode_t mode_i,
   output logic [21:0] access_o,
   output logic [21:0] after_o
);
   logic [20:0] inc;
   logic [20:0] dec;
   // The top bit is carried through untouched so the address space never flips.
   assign inc = ptr_i[20:0] + 21'h000001;
   assign dec = ptr_i[20:0] - 21'h000001;
   always_comb begin
      access_o = ptr_i;
      after_o = ptr_i;
      unique case (mode_i)
         pmta_pkg::PMTA_PLAIN: begin
            after_o = ptr_i;
         end
         pmta_pkg::PMTA_POST_INC: begin
            after_o = {ptr_i[21], inc};
         end
         pmta_pkg::PMTA_POST_DEC: begin
            after_o = {ptr_i[21], dec};
         end
         pmta_pkg::PMTA_PRE_INC: begin
            access_o = {ptr_i[21], inc};
            after_o = {ptr_i[21], inc};
         end
      endcase
   end
endmodule : pmta_ptr_step
`default_nettype wire

/* File: design/pmta_table_access.sv */
// Table-access unit: control register, data latch, byte pointer and array requests.
// Assumes the CPU presents one-cycle register and table requests, and the flash
// array answers reads combinationally and signals the end of a long write.
// What this block does
// - Read start completes in one cycle, self-clears
// - Software may set read start, never clear
// - Read start refused while program memory selected
// - One-byte latch carries each table byte
// - Pointer joins upper, high, low bytes
// - Low 21 bits address program bytes
// - Top bit selects identification and configuration space
// - Auto updates touch only low 21 bits
// - Table read uses all 22 bits
// - Table write picks holding register by bits 2:0
// - Long write programs block from bits 21:3
// - Erase uses block from bits 21:6
// - Plain form leaves pointer unchanged
// - Post-increment accesses then adds one
// - Post-decrement accesses then subtracts one
// - Pre-increment adds one then accesses
// - Erase bit turns next write start into erase
// - Reset during timed write sets error flag
// - Write start refused while write enable clear
// - Firmware sets write start, hardware clears it
`timescale 1ns/10ps
`default_nettype none
module pmta_table_access (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic reg_wr_i,
   input wire logic [2:0] reg_sel_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   input wire pmta_pkg::pmta_tbl_req_t tbl_req_i,
   output logic tbl_done_o,
   output logic [21:0] rd_addr_o,
   output logic rd_cfg_space_o,
   output logic rd_en_o,
   input wire logic [7:0] rd_data_i,
   output logic hold_wr_o,
   output logic [2:0] hold_sel_o,
   output logic [7:0] hold_data_o,
   output logic long_start_o,
   output logic long_erase_o,
   output logic [18:0] wblk_addr_o,
   output logic [15:0] eblk_addr_o,
   input wire logic long_done_i,
   output logic long_busy_o,
   output logic ee_rd_o
);
   typedef struct packed {
      pmta_pkg::pmta_mac_t mac;
      logic [7:0] latch;
      logic [21:0] ptr;
      logic busy;
      logic tbl_done;
      logic hold_wr;
      logic [2:0] hold_sel;
      logic [7:0] hold_data;
      logic long_start;
      logic long_erase;
      logic [21:0] long_ptr;
   } pmta_state_t;

   pmta_state_t st;
   pmta_state_t next_st;
   logic [21:0] acc_ptr;
   logic [21:0] after_ptr;
   logic [7:0] mac_byte;

   pmta_ptr_step u_step (
      .ptr_i(st.ptr),
      .mode_i(tbl_req_i.mode),
      .access_o(acc_ptr),
      .after_o(after_ptr)
   );

   assign mac_byte = {st.mac.sel_pgm, st.mac.sel_cfg, 1'b0, st.mac.erase,
                      st.mac.werr, st.mac.wen, st.mac.wstart, st.mac.rstart};

   always_comb begin
      next_st = st;
      next_st.tbl_done = 1'b0;
      next_st.hold_wr = 1'b0;
      next_st.long_start = 1'b0;
      // A read start lasts exactly one cycle and then clears itself.
      next_st.mac.rstart = 1'b0;
      if (reg_wr_i) begin
         unique case (reg_sel_i)
            pmta_pkg::REG_MAC: begin
               next_st.mac.sel_pgm = reg_wdata_i[pmta_pkg::MAC_SEL_PGM];
               next_st.mac.sel_cfg = reg_wdata_i[pmta_pkg::MAC_SEL_CFG];
               next_st.mac.erase = reg_wdata_i[pmta_pkg::MAC_ERASE];
               next_st.mac.werr = reg_wdata_i[pmta_pkg::MAC_WERR];
               next_st.mac.wen = reg_wdata_i[pmta_pkg::MAC_WEN];
               // Zero writes to the start bits are ignored; only a one acts.
               if (reg_wdata_i[pmta_pkg::MAC_RSTART] && !st.mac.sel_pgm) begin
                  next_st.mac.rstart = 1'b1;
               end
               // The enable is checked as held before this write, so one write
               // cannot both enable and start.
               if (reg_wdata_i[pmta_pkg::MAC_WSTART] && st.mac.wen && !st.busy) begin
                  next_st.mac.wstart = 1'b1;
                  next_st.busy = 1'b1;
                  next_st.long_start = 1'b1;
                  next_st.long_erase = st.mac.erase;
                  next_st.long_ptr = st.ptr;
               end
            end
            pmta_pkg::REG_LATCH: begin
               next_st.latch = reg_wdata_i;
            end
            pmta_pkg::REG_PTR_L: begin
               next_st.ptr[7:0] = reg_wdata_i;
            end
            pmta_pkg::REG_PTR_H: begin
               next_st.ptr[15:8] = reg_wdata_i;
            end
            pmta_pkg::REG_PTR_U: begin
               next_st.ptr[21:16] = reg_wdata_i[5:0];
            end
            default: begin
               next_st.latch = st.latch;
            end
         endcase
      end
      if (st.busy && long_done_i) begin
         next_st.busy = 1'b0;
         next_st.mac.wstart = 1'b0;
      end
      // Table instructions are held off during a long write, as the CPU stalls then.
      if (tbl_req_i.valid && !st.busy) begin
         next_st.tbl_done = 1'b1;
         next_st.ptr = after_ptr;
         if (tbl_req_i.is_write) begin
            next_st.hold_wr = 1'b1;
            next_st.hold_sel = acc_ptr[2:0];
            next_st.hold_data = st.latch;
         end else begin
            next_st.latch = rd_data_i;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         st <= '0;
         st.latch <= pmta_pkg::LATCH_RESET;
         st.ptr <= pmta_pkg::PTR_RESET;
         // Select bits survive reset so software can find the failed location.
         st.mac.sel_pgm <= st.mac.sel_pgm;
         st.mac.sel_cfg <= st.mac.sel_cfg;
         st.mac.werr <= st.mac.werr | st.busy;
      end else begin
         st <= next_st;
      end
   end

   always_comb begin
      unique case (reg_sel_i)
         pmta_pkg::REG_MAC: reg_rdata_o = mac_byte;
         pmta_pkg::REG_LATCH: reg_rdata_o = st.latch;
         pmta_pkg::REG_PTR_L: reg_rdata_o = st.ptr[7:0];
         pmta_pkg::REG_PTR_H: reg_rdata_o = st.ptr[15:8];
         pmta_pkg::REG_PTR_U: reg_rdata_o = {2'b00, st.ptr[21:16]};
         default: reg_rdata_o = 8'h00;
      endcase
   end

   assign rd_en_o = tbl_req_i.valid && !tbl_req_i.is_write && !st.busy;
   assign rd_addr_o = acc_ptr;
   assign rd_cfg_space_o = acc_ptr[pmta_pkg::TOP_BIT];
   assign tbl_done_o = st.tbl_done;
   assign hold_wr_o = st.hold_wr;
   assign hold_sel_o = st.hold_sel;
   assign hold_data_o = st.hold_data;
   assign long_start_o = st.long_start;
   assign long_erase_o = st.long_erase;
   assign wblk_addr_o = st.long_ptr[21:3];
   assign eblk_addr_o = st.long_ptr[21:6];
   assign long_busy_o = st.busy;
   assign ee_rd_o = st.mac.rstart;
endmodule : pmta_table_access
`default_nettype wire

/* File: tb/pmta_assertions.sv */
// Port checks for the table-access unit.
// Assumes one core clock and a synchronous high reset.
`timescale 1ns/10ps
`default_nettype none
module pmta_assertions (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic reg_wr_i,
   input wire logic [2:0] reg_sel_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic tbl_done_o,
   input wire logic rd_en_o,
   input wire logic long_start_o,
   input wire logic long_done_i,
   input wire logic long_busy_o,
   input wire logic ee_rd_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   logic mw;
   // The read path still shows the old control bits in the write cycle.
   assign mw = reg_wr_i && reg_sel_i == 3'h0;
   a_rd_pulse: assert property (mw && reg_wdata_i == 8'h01 && !reg_rdata_o[7] |=> ee_rd_o ##1 !ee_rd_o)
      else $error("read start pulse wrong");
   a_rd_cause: assert property (!mw |=> !ee_rd_o) else $error("read start without write");
   a_rd_refused: assert property (mw && reg_wdata_i[7] && reg_wdata_i[0] && reg_rdata_o[7] |=> !ee_rd_o)
      else $error("read start taken");
   a_wr_refused: assert property (mw && reg_wdata_i[1] && !reg_rdata_o[2] |=> !long_start_o)
      else $error("write start taken");
   a_start_busy: assert property (long_start_o |-> long_busy_o) else $error("start without busy");
   a_start_once: assert property (long_start_o |=> !long_start_o) else $error("start too long");
   a_busy_end: assert property (long_busy_o && long_done_i |=> !long_busy_o) else $error("busy stuck");
   a_read_done: assert property (rd_en_o |=> tbl_done_o) else $error("no table done");
endmodule : pmta_assertions
bind pmta_table_access pmta_assertions chk (.core_clk_i, .rst_i, .reg_wr_i, .reg_sel_i, .reg_wdata_i, .reg_rdata_o,
   .tbl_done_o, .rd_en_o, .long_start_o, .long_done_i, .long_busy_o, .ee_rd_o);
`default_nettype wire

/* File: tb/pmta_flash_model.sv */
// Flash array model: combinational byte reads, timed long operations.
// Assumes the unit drives it from the same core clock.
`timescale 1ns/10ps
`default_nettype none
module pmta_flash_model (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [21:0] rd_addr_i,
   input wire logic rd_en_i,
   input wire logic long_start_i,
   input wire logic [3:0] dly_i,
   output logic [7:0] rd_data_o,
   output logic long_done_o
);
   logic [3:0] cnt;
   // Outside a read the byte is inverted, so a stale value cannot pass.
   assign rd_data_o = {8{!rd_en_i}} ^ rd_addr_i[7:0] ^ {rd_addr_i[21], rd_addr_i[14:8]};
   assign long_done_o = cnt == 4'h1;
   always_ff @(posedge core_clk_i) begin
      if (rst_i) cnt <= 4'h0;
      else if (long_start_i) cnt <= dly_i;
      else if (cnt != 4'h0) cnt <= cnt - 4'h1;
   end
endmodule : pmta_flash_model
`default_nettype wire

/* File: tb/tb.sv */
// Bench for the table-access unit beside a flash array model.
// Assumes the checker binds itself to the unit.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; $display("CHECK FAILED %0t value mismatch", $time); end end
module tb;
   logic core_clk_i, rst_i, reg_wr_i, rd_en_o, rd_cfg_space_o, tbl_done_o, hold_wr_o, long_start_o;
   logic long_erase_o, long_done_i, long_busy_o, ee_rd_o;
   logic [2:0] reg_sel_i, hold_sel_o;
   logic [7:0] reg_wdata_i, reg_rdata_o, rd_data_i, hold_data_o, lat;
   logic [21:0] rd_addr_o, ptr, acc;
   logic [18:0] wblk_addr_o;
   logic [15:0] eblk_addr_o;
   logic [3:0] dly;
   pmta_pkg::pmta_tbl_req_t tbl_req_i;
   int err_count = 0, checks_done = 0;
   pmta_table_access uut (.core_clk_i, .rst_i, .reg_wr_i, .reg_sel_i, .reg_wdata_i, .reg_rdata_o, .tbl_req_i,
      .tbl_done_o, .rd_addr_o, .rd_cfg_space_o, .rd_en_o, .rd_data_i, .hold_wr_o, .hold_sel_o, .hold_data_o,
      .long_start_o, .long_erase_o, .wblk_addr_o, .eblk_addr_o, .long_done_i, .long_busy_o, .ee_rd_o);
   pmta_flash_model flash (.core_clk_i, .rst_i, .rd_addr_i(rd_addr_o), .rd_en_i(rd_en_o),
      .long_start_i(long_start_o), .dly_i(dly), .rd_data_o(rd_data_i), .long_done_o(long_done_i));
   initial begin
      core_clk_i = 1'b0;
      forever #2 core_clk_i = ~core_clk_i;
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test
   task automatic w(input logic [2:0] s, input logic [7:0] d);
      {reg_wr_i, reg_sel_i, reg_wdata_i} = {1'b1, s, d};
      @(posedge core_clk_i) #1;
      reg_wr_i = 1'b0;
      @(posedge core_clk_i) #1;
   endtask : w
   task automatic c(input logic [2:0] s, input logic [7:0] e);
      reg_sel_i = s;
      #1 `CHK(reg_rdata_o, e)
      @(posedge core_clk_i) #1;
   endtask : c
   task automatic setp(input logic [21:0] p);
      for (int i = 0; i < 3; i++) w(3'h2 + 3'(i), 8'(p >> (8 * i)));
      ptr = p;
   endtask : setp
   // Pointer expectations keep bit 21 apart, so a carry into it is caught.
   task automatic tbl(input logic wr, input logic [1:0] m);
      acc = m == 2'h3 ? {ptr[21], ptr[20:0] + 21'h1} : ptr;
      if (m != 2'h0) ptr = {ptr[21], m == 2'h2 ? ptr[20:0] - 21'h1 : ptr[20:0] + 21'h1};
      tbl_req_i = {1'b1, wr, m};
      #1 if (!wr) `CHK({rd_en_o, rd_addr_o, rd_cfg_space_o}, {1'b1, acc, acc[21]})
      @(posedge core_clk_i) #1;
      tbl_req_i.valid = 1'b0;
      if (!wr) lat = acc[7:0] ^ {acc[21], acc[14:8]};
      `CHK({tbl_done_o, hold_wr_o}, {1'b1, wr})
      if (wr) `CHK({hold_sel_o, hold_data_o}, {acc[2:0], lat})
      c(3'h1, lat);
      for (int i = 0; i < 3; i++) c(3'h2 + 3'(i), 8'(ptr >> (8 * i)));
   endtask : tbl
   task automatic t_table();
      for (int i = 0; i < 3; i++) c(3'h1 + 3'(i), 8'h00);
      setp(22'h3FFFFF);
      for (int m = 1; m < 5; m++) tbl(1'b0, 2'(m));
      setp(22'h000000);
      w(3'h1, 8'hA5);
      lat = 8'hA5;
      tbl(1'b1, 2'h2);
      tbl(1'b1, 2'h0);
      $display("table test done");
   endtask : t_table
   task automatic t_control();
      w(3'h0, 8'h00);
      w(3'h0, 8'h01);
      c(3'h0, 8'h00);
      w(3'h0, 8'h80);
      w(3'h0, 8'h81);
      c(3'h0, 8'h80);
      w(3'h0, 8'h02);
      c(3'h0, 8'h00);
      setp(22'h2ABCDE);
      dly = 4'h3;
      w(3'h0, 8'h14);
      w(3'h0, 8'h16);
      `CHK({long_busy_o, long_erase_o, eblk_addr_o}, {2'h3, ptr[21:6]})
      for (int i = 0; i < 20 && long_busy_o; i++) @(posedge core_clk_i) #1;
      #1 `CHK({long_busy_o, reg_rdata_o[2:0]}, 4'h4)
      @(posedge core_clk_i) #1;
      dly = 4'h9;
      w(3'h0, 8'h04);
      w(3'h0, 8'h06);
      `CHK({long_busy_o, long_erase_o, wblk_addr_o}, {2'h2, ptr[21:3]})
      rst_i = 1'b1;
      @(posedge core_clk_i) #1;
      rst_i = 1'b0;
      c(3'h0, 8'h08);
      $display("control test done");
   endtask : t_control
   initial begin
      {reg_wr_i, reg_sel_i, reg_wdata_i, tbl_req_i, dly, ptr, lat} = '0;
      rst_i = 1'b1;
      repeat (6) @(posedge core_clk_i);
      #1 rst_i = 1'b0;
      t_table();
      t_control();
      stop_test();
   end
   initial begin
      #4000;
      err_count++;
      stop_test();
   end
endmodule : tb
`default_nettype wire
